/* bench/sfp_host_model.sv */
// host spi controller model: mode 0, msb first, link clock only inside frames
// assumes: the device replies on io1 after falling edges of sclk
`timescale 1ns/10ps
`default_nettype none
module sfp_host_model (
	output logic sclk,
	output logic cs_n,
	output logic io0_in,
	input wire logic io1_out,
	input wire logic io1_oe,
	input wire logic io0_oe
);
	logic [15:0] rx;
	int first_oe;
	logic dual_seen;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io0_in = 1'b0;
		rx = 16'h0000;
		first_oe = -1;
		dual_seen = 1'b0;
	end

	// ----------------------------------------------------------------
	// one frame: nb bits out, then rb reply bits in
	// ----------------------------------------------------------------
	// msb first, one frame per select
	task automatic xfer(input logic [63:0] tx, input int nb, input int rb);
		int i;
		#1.3;
		cs_n = 1'b0;
		first_oe = -1;
		dual_seen = 1'b0;
		rx = 16'h0000;
		#24;
		for (i = 0; i < nb + rb; i++) begin
			// past the command the line is don't-care, so keep it toggling
			io0_in = (i < nb) ? tx[63-i] : ~io0_in;
			#24;
			sclk = 1'b1;
			if (io1_oe === 1'b1 && first_oe < 0) begin
				first_oe = i;
				dual_seen = io0_oe;
			end
			if (i >= nb) begin
				// a released line reads as the inverse, so a missing enable shows
				rx = {rx[14:0], (io1_oe === 1'b1) ? io1_out : ~io1_out};
			end
			#24;
			sclk = 1'b0;
		end
		#4;
		cs_n = 1'b1;
		io0_in = ~io0_in;
		#48;
	endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the flash protect and command framing block
// assumes: host model makes the 48 ns link clock, bench drives the rest
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import sfp_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic wp_n = 1'b1;
	logic erase_active = 1'b0;
	logic program_active = 1'b0;
	logic array_busy = 1'b0;
	logic prog_ready = 1'b1;
	wire logic sclk, cs_n, io0_in, io0_out, io0_oe, io1_out, io1_oe;
	logic [7:0] prog_data, op_code;
	logic [7:0] got_prog = 8'h00;
	logic [23:0] op_addr;
	logic [15:0] status_word;
	logic prog_valid, op_start, pins_are_data, deep_power_down, overrun;
	int bad_count = 0;
	int tests_run = 0;
	int op_count = 0;

	always #2 sys_clk = ~sys_clk;

	// sampled mid-cycle, away from the edge that launches the pulse
	always @(negedge sys_clk) begin
		if (op_start === 1'b1) begin
			op_count <= op_count + 1;
		end
		if (prog_valid === 1'b1 && prog_ready === 1'b1) begin
			got_prog <= prog_data;
		end
	end

	sfp_cmd_frame i_sfp_cmd_frame (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n),
		.io0_in(io0_in), .io0_out(io0_out), .io0_oe(io0_oe), .io1_out(io1_out),
		.io1_oe(io1_oe), .wp_n(wp_n), .erase_active(erase_active),
		.program_active(program_active), .array_busy(array_busy), .prog_data(prog_data),
		.prog_valid(prog_valid), .prog_ready(prog_ready), .op_start(op_start),
		.op_code(op_code), .op_addr(op_addr), .status_word(status_word),
		.pins_are_data(pins_are_data), .deep_power_down(deep_power_down), .overrun(overrun));

	sfp_host_model i_sfp_host_model (.sclk(sclk), .cs_n(cs_n), .io0_in(io0_in),
		.io1_out(io1_out), .io1_oe(io1_oe), .io0_oe(io0_oe));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic settle;
		repeat (40) @(negedge sys_clk);
	endtask

	task automatic fr(input logic [63:0] t, input int nb, input int rb);
		i_sfp_host_model.xfer(t, nb, rb);
	endtask

	task automatic cmd(input logic [7:0] op, input int nb);
		fr({op, 56'h0}, nb, 0);
		settle;
	endtask

	task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
		cmd(OP_WREN, 8);
		fr({OP_WRSR, lo, hi, 40'h0}, 24, 0);
		settle;
	endtask

	task automatic power_cycle;
		@(negedge sys_clk);
		rst_b = 1'b0;
		repeat (4) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_status;
		chk("status after reset", 16'h0000, status_word);
		fr({OP_WRSR, 8'h1c, 8'h40, 40'h0}, 24, 0);
		settle;
		chk("write without latch", 16'h0000, status_word);
		cmd(OP_WREN, 8);
		fr({OP_RDSR_LO, 56'h0}, 8, 8);
		chk("low byte read", 8'h02, i_sfp_host_model.rx[7:0]);
		chk("reply start", 24'(8), 24'(i_sfp_host_model.first_oe));
		fr({OP_WRSR, 8'h1c, 8'h40, 40'h0}, 24, 0);
		settle;
		chk("status written", 16'h401c, status_word);
		fr({OP_RDSR_HI, 56'h0}, 8, 16);
		chk("high byte repeated", 16'h4040, i_sfp_host_model.rx);
		array_busy = 1'b1;
		settle;
		chk("busy bit", 1'b1, status_word[BIT_WIP]);
		array_busy = 1'b0;
		$display("test status done");
	endtask

	task automatic t_boundary;
		cmd(OP_WREN, 9);
		chk("latch on 9 bits", 1'b0, status_word[BIT_LATCH]);
		cmd(OP_WREN, 8);
		fr({OP_PP, 24'h000100, 8'ha5, 24'h0}, 36, 0);
		settle;
		chk("latch after partial", 1'b1, status_word[BIT_LATCH]);
		chk("no op on partial", 24'(0), 24'(op_count));
		cmd(OP_WRDI, 7);
		chk("latch on 7 bits", 1'b1, status_word[BIT_LATCH]);
		cmd(OP_WRDI, 8);
		chk("latch cleared", 1'b0, status_word[BIT_LATCH]);
		cmd(OP_DPD, 7);
		chk("power down partial", 1'b0, deep_power_down);
		cmd(OP_DPD, 8);
		chk("power down", 1'b1, deep_power_down);
		cmd(OP_RDP, 8);
		chk("power up", 1'b0, deep_power_down);
		$display("test boundary done");
	endtask

	task automatic t_program;
		logic [7:0] ops [3] = '{OP_SE, OP_BE32, OP_BE64};
		int n;
		cmd(OP_WREN, 8);
		@(negedge sys_clk);
		prog_ready = 1'b0;
		fr({OP_PP, 24'h123456, 8'ha5, 24'h0}, 40, 0);
		settle;
		chk("stalled byte", {1'b1, 8'ha5}, {prog_valid, prog_data});
		chk("no op while stalled", 24'(0), 24'(op_count));
		prog_ready = 1'b1;
		settle;
		chk("program op", {OP_PP, 24'h123456}, {op_code, op_addr});
		chk("program byte", 8'ha5, got_prog);
		chk("latch after program", 1'b0, status_word[BIT_LATCH]);
		for (int i = 0; i < 3; i++) begin
			n = op_count;
			cmd(OP_WREN, 8);
			fr({ops[i], 24'h0a0b0c, 32'h0}, 32, 0);
			settle;
			chk("erase op", {ops[i], 24'h0a0b0c}, {op_code, op_addr});
			chk("erase count", 24'(n + 1), 24'(op_count));
		end
		n = op_count;
		fr({OP_SE, 24'h0a0b0c, 32'h0}, 32, 0);
		settle;
		chk("erase without latch", 24'(n), 24'(op_count));
		$display("test program done");
	endtask

	task automatic t_protect;
		power_cycle;
		wrsr(8'h80, 8'h00);
		chk("hw mode set", 16'h0080, status_word);
		wp_n = 1'b0;
		wrsr(8'h84, 8'h00);
		chk("hw locked", 16'h0080, status_word & 16'hfffd);
		wp_n = 1'b1;
		wrsr(8'h84, 8'h00);
		chk("hw unlocked", 16'h0084, status_word);
		wrsr(8'h00, 8'h01);
		chk("lockdown set", 16'h0100, status_word);
		wrsr(8'h04, 8'h00);
		chk("lockdown refuses", 16'h0100, status_word & 16'hfffd);
		power_cycle;
		chk("lockdown cleared", 16'h0000, status_word);
		wrsr(8'h80, 8'h01);
		wrsr(8'h00, 8'h00);
		chk("one time mode", 16'h0180, status_word & 16'hfffd);
		power_cycle;
		$display("test protect done");
	endtask

	task automatic t_quad_lock;
		wrsr(8'h00, 8'h0a);
		chk("quad and lock", 16'h0a00, status_word);
		chk("pins as data", 1'b1, pins_are_data);
		wp_n = 1'b0;
		wrsr(8'h00, 8'h00);
		chk("lock kept", 16'h0800, status_word);
		chk("pins as control", 1'b0, pins_are_data);
		wp_n = 1'b1;
		power_cycle;
		$display("test quad lock done");
	endtask

	task automatic t_suspend;
		erase_active = 1'b1;
		cmd(OP_SUSPEND, 8);
		chk("erase suspended", 16'h8000, status_word);
		fr({OP_RDSR_HI, 56'h0}, 8, 8);
		chk("flag read back", 8'h80, i_sfp_host_model.rx[7:0]);
		cmd(OP_RESUME, 8);
		chk("resume clears", 16'h0000, status_word);
		erase_active = 1'b0;
		program_active = 1'b1;
		cmd(OP_SUSPEND, 8);
		chk("program suspended", 16'h0400, status_word);
		cmd(OP_RSTEN, 8);
		cmd(OP_RST, 8);
		chk("reset clears", 16'h0000, status_word);
		program_active = 1'b0;
		$display("test suspend done");
	endtask

	task automatic t_reads;
		logic [7:0] ops [6] = '{OP_READ, OP_FREAD, OP_DREAD, OP_QREAD, OP_DIOREAD, OP_QIOREAD};
		int hdr [6] = '{32, 40, 40, 40, 40, 56};
		for (int i = 0; i < 6; i++) begin
			fr({ops[i], 56'h0}, hdr[i], 8);
			chk("data start", 24'(hdr[i]), 24'(i_sfp_host_model.first_oe));
			chk("read data", 8'h00, i_sfp_host_model.rx[7:0]);
			chk("outputs released", 2'b00, {io0_oe, io1_oe});
			chk("io0 idle", 1'b0, io0_out);
			if (ops[i] == OP_DREAD || ops[i] == OP_DIOREAD) begin
				chk("second line", 1'b1, i_sfp_host_model.dual_seen);
			end
		end
		fr({OP_RDSR_LO, 56'h0}, 8, 3);
		chk("early end", 2'b00, {io0_oe, io1_oe});
		settle;
		chk("no overrun", 1'b0, overrun);
		$display("test reads done");
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_status;
		t_boundary;
		t_program;
		t_protect;
		t_quad_lock;
		t_suspend;
		t_reads;
		wrap_up;
	end

	// about 50k system cycles, over twice what the frames should need
	initial begin
		#200000;
		bad_count++;
		wrap_up;
	end
endmodule
`default_nettype wire

/* hw/sfp_cmd_frame.sv */
// serial flash command framing and status-word protection logic
// assumes: sclk and cs_n come from an SPI host; array side on sys_clk
// What this block does
// - protect mode 00 allows status write only with write enable latch set.
// - protect mode 01 with write-protect pin low locks status writes unless quad enable is set.
// - protect mode 01 with pin high allows status write when latch set.
// - protect mode 10 refuses status writes until reset; reset clears mode.
// - protect mode 11 refuses status writes until reset; reset clears mode.
// - quad enable set turns write-protect and hold pins into data lines.
// - three lock bits are one-time set, never cleared by a write.
// - complement protect bit stored, offered with block protect bits.
// - suspend sets erase or program suspended flag per active operation.
// - resume, enable-reset plus reset, or power cycle clear suspend flags.
// - bits shift in msb first, latched on sclk rising edges.
// - each frame is one opcode byte then optional address and data.
// - reads end at any bit when cs_n rises; outputs released.
// - write-type commands execute only on a whole number of bytes.
// - page program with a partial byte raises no op_start, latch stays set.
// - dual output read: opcode, three address bytes, dummy, two-line data.
// - with the latch clear no status write, program or erase is taken.
`timescale 1ns/10ps
`default_nettype none

module sfp_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} sfp_fifo_t;
	sfp_fifo_t r, next_r;
	logic do_push, do_pop;

	assign in_ready = r.cnt != (AW+1)'(DEPTH);
	assign out_valid = r.cnt != '0;
	assign out_data = r.mem[r.rd];

	always_comb begin
		next_r = r;
		do_push = in_valid && in_ready;
		do_pop = out_valid && out_ready;
		if (do_push) begin
			next_r.mem[r.wr] = in_data;
			next_r.wr = (r.wr == AW'(DEPTH-1)) ? '0 : r.wr + 1'b1;
		end
		if (do_pop) begin
			next_r.rd = (r.rd == AW'(DEPTH-1)) ? '0 : r.rd + 1'b1;
		end
		if (do_push && !do_pop) begin
			next_r.cnt = r.cnt + 1'b1;
		end else if (do_pop && !do_push) begin
			next_r.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule

// ----------------------------------------------------------------
// link side: runs on sclk only while a frame is open
// ----------------------------------------------------------------
module sfp_link (
	input wire logic sclk,
	input wire logic rst_b,
	input wire logic cs_n,
	input wire logic io0_in,
	input wire logic tx_bit,
	input wire logic tx_oe,
	input wire logic dual_oe,
	output logic bit_tog,
	output logic bit_val,
	output logic io0_out,
	output logic io0_oe,
	output logic io1_out,
	output logic io1_oe
);
	typedef struct packed {
		logic tog;
		logic val;
	} sfp_rise_t;
	typedef struct packed {
		logic io0;
		logic io0_oe;
		logic io1;
		logic io1_oe;
	} sfp_fall_t;
	sfp_rise_t rr, next_rr;
	sfp_fall_t fr, next_fr;
	logic frame_rst_b;

	// cs_n high ends drive at once: sclk may never tick again
	assign frame_rst_b = rst_b & ~cs_n;
	assign bit_tog = rr.tog;
	assign bit_val = rr.val;
	assign io0_out = fr.io0;
	assign io0_oe = fr.io0_oe;
	assign io1_out = fr.io1;
	assign io1_oe = fr.io1_oe;

	always_comb begin
		next_rr = rr;
		next_rr.tog = ~rr.tog;
		next_rr.val = io0_in;
		// tx_bit is set by sys_clk on the third sys_clk edge after the sclk rise, before this edge
		next_fr.io0 = 1'b0;
		next_fr.io0_oe = dual_oe;
		next_fr.io1 = tx_bit;
		next_fr.io1_oe = tx_oe;
	end

	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			rr <= '0;
		end else begin
			rr <= next_rr;
		end
	end

	always_ff @(negedge sclk or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			fr <= '0;
		end else begin
			fr <= next_fr;
		end
	end
endmodule

// ----------------------------------------------------------------
// top: framing, fifo, command execution, status word
// ----------------------------------------------------------------
module sfp_cmd_frame (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic io0_in,
	output logic io0_out,
	output logic io0_oe,
	output logic io1_out,
	output logic io1_oe,
	input wire logic wp_n,
	input wire logic erase_active,
	input wire logic program_active,
	input wire logic array_busy,
	output logic [7:0] prog_data,
	output logic prog_valid,
	input wire logic prog_ready,
	output logic op_start,
	output logic [7:0] op_code,
	output logic [23:0] op_addr,
	output logic [15:0] status_word,
	output logic pins_are_data,
	output logic deep_power_down,
	output logic overrun
);
	import sfp_pkg::*;

	typedef struct packed {
		logic cs_s1, cs_s2, cs_d;
		logic tg_s1, tg_s2, tg_d;
		logic wp_s1, wp_s2;
		logic [2:0] bit_cnt;
		logic [6:0] shift;
		logic [2:0] nbytes;
		logic [7:0] opc;
		logic [7:0] reply;
		logic reply_on;
		logic tx_bit, tx_oe, dual_oe;
		logic overrun;
		sfp_state_t st;
		logic [7:0] cmd;
		logic [2:0] idx;
		logic [23:0] addr;
		logic [7:0] wr_lo, wr_hi;
		logic [15:0] stw;
		logic armed;
		logic dpd;
		logic [7:0] pdata;
		logic pvalid;
		logic ostart;
		logic [7:0] ocode;
		logic [23:0] oaddr;
		logic [15:0] stat_out;
		logic quad_out;
	} sfp_sys_t;
	sfp_sys_t r, next_r;

	logic bit_tog, bit_val;
	logic push_valid, push_ready;
	logic [ENT_W-1:0] push_data;
	logic ent_valid, ent_ready;
	logic [ENT_W-1:0] ent;
	logic bit_ev, frame_end, byte_done, whole, exec;
	logic [7:0] in_byte, opc_now;
	logic [15:0] sv, wr_word;
	logic [1:0] pmode;
	logic stw_open, wrsr_ok, write_cmd, is_prog, is_read;
	logic [2:0] hdr;

	sfp_link u_link (
		.sclk(sclk),
		.rst_b(rst_b),
		.cs_n(cs_n),
		.io0_in(io0_in),
		.tx_bit(r.tx_bit),
		.tx_oe(r.tx_oe),
		.dual_oe(r.dual_oe),
		.bit_tog(bit_tog),
		.bit_val(bit_val),
		.io0_out(io0_out),
		.io0_oe(io0_oe),
		.io1_out(io1_out),
		.io1_oe(io1_oe)
	);

	sfp_fifo #(.WIDTH(ENT_W), .DEPTH(ENT_DEPTH)) u_fifo (
		.clk(sys_clk),
		.rst_b(rst_b),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(ent_valid),
		.out_ready(ent_ready),
		.out_data(ent)
	);

	// draining stalls while a program byte waits on the array
	assign ent_ready = r.st != ST_PUSH;
	assign prog_data = r.pdata;
	assign prog_valid = r.pvalid;
	assign op_start = r.ostart;
	assign op_code = r.ocode;
	assign op_addr = r.oaddr;
	assign status_word = r.stat_out;
	assign pins_are_data = r.quad_out;
	assign deep_power_down = r.dpd;
	assign overrun = r.overrun;

	always_comb begin
		next_r = r;
		next_r.ostart = 1'b0;
		// ----------------------------------------------------------------
		// crossings
		// ----------------------------------------------------------------
		next_r.cs_s1 = cs_n;
		next_r.cs_s2 = r.cs_s1;
		next_r.cs_d = r.cs_s2;
		next_r.tg_s1 = bit_tog;
		next_r.tg_s2 = r.tg_s1;
		next_r.tg_d = r.tg_s2;
		next_r.wp_s1 = wp_n;
		next_r.wp_s2 = r.wp_s1;
		bit_ev = r.tg_s2 != r.tg_d;
		frame_end = r.cs_s2 && !r.cs_d;
		in_byte = {r.shift, bit_val};
		byte_done = bit_ev && (r.bit_cnt == 3'd7);
		opc_now = (r.nbytes == 3'd0) ? in_byte : r.opc;
		sv = r.stw | {15'h0000, array_busy};
		push_valid = 1'b0;
		push_data = '0;
		is_read = (opc_now == OP_READ) || (opc_now == OP_FREAD) || (opc_now == OP_DREAD)
			|| (opc_now == OP_QREAD) || (opc_now == OP_DIOREAD) || (opc_now == OP_QIOREAD);
		hdr = (opc_now == OP_READ) ? HDR_READ : ((opc_now == OP_QIOREAD) ? HDR_QIO : HDR_FAST);
		// ----------------------------------------------------------------
		// bit assembly and read replies
		// ----------------------------------------------------------------
		if (bit_ev) begin
			next_r.shift = in_byte[6:0];
			next_r.bit_cnt = r.bit_cnt + 3'd1;
			// only a status reply shifts out; stale bits never reach array reads
			next_r.tx_bit = r.reply_on & r.reply[7];
			next_r.reply = {r.reply[6:0], 1'b0};
		end
		if (byte_done) begin
			push_valid = 1'b1;
			push_data = {2'b00, in_byte};
			if (r.nbytes != 3'd7) begin
				next_r.nbytes = r.nbytes + 3'd1;
			end
			if (r.nbytes == 3'd0) begin
				next_r.opc = in_byte;
			end
			// status reads repeat the same byte until cs_n rises
			if (opc_now == OP_RDSR_LO || opc_now == OP_RDSR_HI) begin
				next_r.reply = (opc_now == OP_RDSR_LO) ? {sv[6:0], 1'b0} : {sv[14:8], 1'b0};
				next_r.tx_bit = (opc_now == OP_RDSR_LO) ? sv[7] : sv[15];
				next_r.reply_on = 1'b1;
				next_r.tx_oe = 1'b1;
			end else if (is_read && (r.nbytes + 3'd1 == hdr)) begin
				// data after header; array data not modelled here
				next_r.tx_bit = 1'b0;
				next_r.tx_oe = 1'b1;
				next_r.dual_oe = (opc_now == OP_DREAD) || (opc_now == OP_DIOREAD);
			end
		end
		if (frame_end) begin
			push_valid = 1'b1;
			push_data = {1'b1, r.bit_cnt != 3'd0, 8'h00};
			next_r.bit_cnt = 3'd0;
			next_r.nbytes = 3'd0;
			next_r.reply_on = 1'b0;
			next_r.tx_oe = 1'b0;
			next_r.dual_oe = 1'b0;
			next_r.tx_bit = 1'b0;
		end
		if (push_valid && !push_ready) begin
			next_r.overrun = 1'b1;
		end
		// ----------------------------------------------------------------
		// command execution
		// ----------------------------------------------------------------
		exec = 1'b0;
		whole = !ent[ENT_PART];
		case (r.st)
			ST_WAIT_OP: begin
				if (ent_valid && !ent[ENT_END]) begin
					next_r.cmd = ent[7:0];
					next_r.idx = 3'd1;
					next_r.st = ST_BODY;
				end
			end
			ST_BODY: begin
				if (ent_valid && ent[ENT_END]) begin
					exec = 1'b1;
					next_r.st = ST_WAIT_OP;
				end else if (ent_valid) begin
					if (r.idx != 3'd7) begin
						next_r.idx = r.idx + 3'd1;
					end
					if (r.idx <= 3'd3) begin
						next_r.addr = {r.addr[15:0], ent[7:0]};
					end
					if (r.idx == 3'd1) begin
						next_r.wr_lo = ent[7:0];
					end
					if (r.idx == 3'd2) begin
						next_r.wr_hi = ent[7:0];
					end
					if ((r.cmd == OP_PP || r.cmd == OP_QPP) && r.idx >= 3'd4) begin
						next_r.pdata = ent[7:0];
						next_r.pvalid = 1'b1;
						next_r.st = ST_PUSH;
					end
				end
			end
			ST_PUSH: begin
				if (prog_ready) begin
					next_r.pvalid = 1'b0;
					next_r.st = ST_BODY;
				end
			end
			default: begin
				next_r.st = ST_WAIT_OP;
			end
		endcase
		pmode = {r.stw[BIT_PM_HI], r.stw[BIT_PM_LO]};
		// protect mode gate, pin ignored when it is a data line
		// lock-down and one-time modes never open
		stw_open = (pmode == PM_SOFT) || ((pmode == PM_HW) && (r.wp_s2 || r.stw[BIT_QUAD]));
		wrsr_ok = exec && whole && r.cmd == OP_WRSR && r.stw[BIT_LATCH] && stw_open
			&& r.idx >= 3'd2 && !r.dpd;
		wr_word = {(r.idx >= 3'd3) ? r.wr_hi : r.stw[15:8], r.wr_lo};
		is_prog = r.cmd == OP_PP || r.cmd == OP_QPP;
		write_cmd = is_prog || r.cmd == OP_SE || r.cmd == OP_BE32 || r.cmd == OP_BE64
			|| r.cmd == OP_CE_A || r.cmd == OP_CE_B;
		if (exec) begin
			next_r.armed = 1'b0;
		end
		// only whole-byte frames run; a partial one keeps the latch
		if (exec && whole && !(r.dpd && r.cmd != OP_RDP)) begin
			case (r.cmd)
				OP_WREN: next_r.stw[BIT_LATCH] = 1'b1;
				OP_WRDI: next_r.stw[BIT_LATCH] = 1'b0;
				OP_DPD: next_r.dpd = 1'b1;
				OP_RDP: next_r.dpd = 1'b0;
				OP_SUSPEND: begin
					if (erase_active) begin
						next_r.stw[BIT_ESUS] = 1'b1;
					end
					if (program_active) begin
						next_r.stw[BIT_PSUS] = 1'b1;
					end
				end
				OP_RESUME: begin
					next_r.stw[BIT_ESUS] = 1'b0;
					next_r.stw[BIT_PSUS] = 1'b0;
				end
				OP_RSTEN: next_r.armed = 1'b1;
				OP_RST: begin
					if (r.armed) begin
						next_r.stw[BIT_ESUS] = 1'b0;
						next_r.stw[BIT_PSUS] = 1'b0;
						next_r.stw[BIT_LATCH] = 1'b0;
					end
				end
				default: begin
					// program and sector/block erase need latch and full address; chip erase needs the latch only
					if (write_cmd && r.stw[BIT_LATCH]
						&& (r.idx >= 3'd4 || r.cmd == OP_CE_A || r.cmd == OP_CE_B)) begin
						next_r.ostart = 1'b1;
						next_r.ocode = r.cmd;
						next_r.oaddr = r.addr;
						next_r.stw[BIT_LATCH] = 1'b0;
					end
				end
			endcase
		end
		if (wrsr_ok) begin
			// lock bits only ever set; complement bit stored
			next_r.stw = (r.stw & ~STW_WMASK) | (wr_word & STW_WMASK)
				| (r.stw & STW_LOCK_MASK);
			next_r.stw[BIT_LATCH] = 1'b0;
		end
		next_r.stat_out = next_r.stw | {15'h0000, array_busy};
		next_r.quad_out = next_r.stw[BIT_QUAD];
	end

	// reset stands for a power cycle: every status bit returns to zero
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1, wp_s1: 1'b1, wp_s2: 1'b1,
				stw: STW_RESET, st: ST_WAIT_OP, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	wrsr_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(exec && r.cmd == OP_WRSR && !r.stw[BIT_LATCH]) |=> $stable(r.stw & STW_WMASK))
		else $error("status write taken without latch");
	hw_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(exec && pmode == PM_HW && !r.wp_s2 && !r.stw[BIT_QUAD])
		|=> $stable(r.stw & STW_WMASK))
		else $error("hardware protect let a write through");
	psl_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		pmode == PM_PSL |=> {r.stw[BIT_PM_HI], r.stw[BIT_PM_LO]} == PM_PSL)
		else $error("lock-down mode changed without reset");
	otp_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		pmode == PM_OTP |=> $stable(r.stw & STW_WMASK))
		else $error("one-time protect mode changed");
	lock_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		((r.stw & STW_LOCK_MASK) != 16'h0000) |=> ((r.stw & $past(r.stw) & STW_LOCK_MASK)
		== ($past(r.stw) & STW_LOCK_MASK)))
		else $error("lock bit cleared");
	suspend_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(exec && whole && !r.dpd && r.cmd == OP_SUSPEND && erase_active)
		|=> r.stw[BIT_ESUS] ##1 status_word[BIT_ESUS])
		else $error("erase suspend flag not set");
	resume_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(exec && whole && !r.dpd && r.cmd == OP_RESUME)
		|=> !r.stw[BIT_ESUS] && !r.stw[BIT_PSUS])
		else $error("resume left a suspend flag");
	partial_reject_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(exec && !whole) |=> !r.ostart && $stable(r.stw))
		else $error("partial frame executed");
	pp_partial_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(exec && !whole && r.cmd == OP_PP && r.stw[BIT_LATCH]) |=> r.stw[BIT_LATCH])
		else $error("partial program cleared latch");
endmodule

`default_nettype wire

/* shared/sfp_pkg.sv */
// constants and types for the serial flash protect / command framing block
// assumes: an SPI host on the far side, 8-bit opcodes, 24-bit addresses
package sfp_pkg;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR_LO = 8'h05;
	localparam logic [7:0] OP_RDSR_HI = 8'h35;
	localparam logic [7:0] OP_VWREN = 8'h50;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0b;
	localparam logic [7:0] OP_DREAD = 8'h3b;
	localparam logic [7:0] OP_QREAD = 8'h6b;
	localparam logic [7:0] OP_DIOREAD = 8'hbb;
	localparam logic [7:0] OP_QIOREAD = 8'heb;
	localparam logic [7:0] OP_WRAP = 8'h77;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_QPP = 8'h32;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hd8;
	localparam logic [7:0] OP_CE_A = 8'h60;
	localparam logic [7:0] OP_CE_B = 8'hc7;
	localparam logic [7:0] OP_DPD = 8'hb9;
	localparam logic [7:0] OP_RDP = 8'hab;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_RSTEN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;

	// ----------------------------------------------------------------
	// status word layout
	// ----------------------------------------------------------------
	localparam int BIT_WIP = 0;
	localparam int BIT_LATCH = 1;
	localparam int BIT_PM_LO = 7;
	localparam int BIT_PM_HI = 8;
	localparam int BIT_QUAD = 9;
	localparam int BIT_PSUS = 10;
	localparam int BIT_COMPL = 14;
	localparam int BIT_ESUS = 15;
	localparam logic [15:0] STW_RESET = 16'h0000;
	localparam logic [15:0] STW_WMASK = 16'h7bfc;
	localparam logic [15:0] STW_LOCK_MASK = 16'h3800;

	// protect modes {hi, lo}
	localparam logic [1:0] PM_SOFT = 2'b00;
	localparam logic [1:0] PM_HW = 2'b01;
	localparam logic [1:0] PM_PSL = 2'b10;
	localparam logic [1:0] PM_OTP = 2'b11;

	// ----------------------------------------------------------------
	// frame fifo entry: {end, partial, byte}
	// ----------------------------------------------------------------
	localparam int ENT_W = 10;
	localparam int ENT_DEPTH = 8;
	localparam int ENT_END = 9;
	localparam int ENT_PART = 8;
	localparam logic [2:0] HDR_READ = 3'd4;
	localparam logic [2:0] HDR_FAST = 3'd5;
	localparam logic [2:0] HDR_QIO = 3'd7;

	typedef enum logic [1:0] {
		ST_WAIT_OP = 2'b00,
		ST_BODY = 2'b01,
		ST_PUSH = 2'b11
	} sfp_state_t;

endpackage
